// ===== hdl/ecc_counter.sv
// edge counters with comparison values, flag byte and cascade mode
`include "ecc_regs.svh"
module ecc_counter
    import ecc_pkg::*;
(
    input  wire logic         clock,          // system clock, 200 MHz
    input  wire logic         rst,            // synchronous reset
    input  wire logic         pin_first,      // first counter pin
    input  wire logic         pin_second,     // second counter pin
    input  wire ecc_edge_type cfg_first_edge, // stored cfg, first edge
    input  wire ecc_edge_type cfg_second_edge,// stored cfg, second edge
    input  wire logic         cfg_cascade,    // stored cfg, cascade on
    input  wire logic [31:0]  cfg_compare,    // stored cfg compare(s)
    input  wire logic         start,          // load stored configuration
    input  wire logic [7:0]   word_addr,      // word address of access
    input  wire logic         word_rd,        // direct read strobe
    input  wire logic         word_wr,        // write strobe
    input  wire logic [15:0]  primary_accumulator,   // later loaded word
    input  wire logic [15:0]  secondary_accumulator, // earlier loaded word
    output logic [15:0]       word_rdata,     // direct read data
    input  wire logic         image_update,   // sample input image
    output logic [15:0]       image_first,    // image of word 36
    output logic [15:0]       image_second,   // image of word 38
    input  wire logic         handler_enter,  // handler entry pulse
    input  wire logic         handler_exit,   // handler end pulse
    input  wire logic [1:0]   flag_clr,       // per-bit reset writes
    output logic [7:0]        counter_event_flag_byte, // flag byte
    output logic              counter_irq     // request pulse
);
    // ------------------------------------------------------------
    // edge qualification
    // ------------------------------------------------------------
    ecc_edge_type edge_first_q;  // active edge, first input
    ecc_edge_type edge_second_q; // active edge, second input
    logic         cascade_q;     // cascade active
    logic         hit_first;     // qualified edge, first input
    logic         hit_second;    // qualified edge, second input

    ecc_edge_sync u_sync_first (
        .clock    (clock),
        .rst      (rst),
        .pin      (pin_first),
        .edge_sel (edge_first_q),
        .edge_hit (hit_first)
    );
    ecc_edge_sync u_sync_second (
        .clock    (clock),
        .rst      (rst),
        .pin      (pin_second),
        // second input is dead while cascaded
        .edge_sel (cascade_q ? ECC_OFF : edge_second_q),
        .edge_hit (hit_second)
    );

    // ------------------------------------------------------------
    // active configuration
    // ------------------------------------------------------------
    logic [31:0] cmp_q;   // active compare; low half = first counter
    logic [31:0] cnt_q;   // count; low half = first, high = second
    logic        wr_first;  // write to word 36
    logic        wr_second; // write to word 38
    assign wr_first  = word_wr && (word_addr == `ECC_WORD_FIRST);
    assign wr_second = word_wr && (word_addr == `ECC_WORD_SECOND);

    // stored settings are only copied, never written back
    always_ff @(posedge clock) begin
        if (rst) begin
            edge_first_q  <= ECC_OFF;
            edge_second_q <= ECC_OFF;
            cascade_q     <= 1'b0;
        end else if (start) begin
            edge_first_q  <= cfg_first_edge;
            edge_second_q <= cfg_second_edge;
            cascade_q     <= cfg_cascade;
        end
    end

    // comparison values: stored at start, replaced by writes to word 36 or, outside cascade, word 38
    always_ff @(posedge clock) begin
        if (rst) begin
            cmp_q <= `ECC_ZERO32;
        end else if (start) begin
            cmp_q <= cfg_compare;
        end else if (cascade_q && wr_first) begin
            cmp_q <= {secondary_accumulator, primary_accumulator};
        end else if (!cascade_q && wr_first) begin
            cmp_q[15:0] <= primary_accumulator;
        end else if (!cascade_q && wr_second) begin
            cmp_q[31:16] <= primary_accumulator;
        end
    end

    // ------------------------------------------------------------
    // counting
    // ------------------------------------------------------------
    logic match_first;   // first counter at compare
    logic match_second;  // second counter at compare
    logic match_casc;    // cascade at compare
    logic [15:0] nxt_first;  // first counter after this cycle
    logic [15:0] nxt_second; // second counter after this cycle
    logic [31:0] nxt_casc;   // cascade after this cycle

    always_comb begin
        nxt_first  = hit_first ? cnt_q[15:0] + `ECC_ONE16 : cnt_q[15:0];
        nxt_second = hit_second ? cnt_q[31:16] + `ECC_ONE16
                                : cnt_q[31:16];
        nxt_casc   = hit_first ? cnt_q + `ECC_ONE32 : cnt_q;
    end
    // reaching the compare value counts as the event
    assign match_casc   = cascade_q && (edge_first_q != ECC_OFF)
                          && hit_first && (nxt_casc == cmp_q);
    assign match_first  = !cascade_q && (edge_first_q != ECC_OFF)
                          && hit_first && (nxt_first == cmp_q[15:0]);
    assign match_second = !cascade_q && (edge_second_q != ECC_OFF)
                          && hit_second && (nxt_second == cmp_q[31:16]);

    // a write clears but an edge in the same cycle still counts
    always_ff @(posedge clock) begin
        if (rst || start) begin
            cnt_q <= `ECC_ZERO32;
        end else if (cascade_q) begin
            if (match_casc) begin
                cnt_q <= `ECC_ZERO32;
            end else if (wr_first || wr_second) begin
                cnt_q <= hit_first ? `ECC_ONE32 : `ECC_ZERO32;
            end else begin
                cnt_q <= nxt_casc;
            end
        end else begin
            if (match_first) begin
                cnt_q[15:0] <= `ECC_ZERO16;
            end else if (wr_first) begin
                cnt_q[15:0] <= hit_first ? `ECC_ONE16 : `ECC_ZERO16;
            end else begin
                cnt_q[15:0] <= nxt_first;
            end
            if (match_second) begin
                cnt_q[31:16] <= `ECC_ZERO16;
            end else if (wr_second) begin
                cnt_q[31:16] <= hit_second ? `ECC_ONE16 : `ECC_ZERO16;
            end else begin
                cnt_q[31:16] <= nxt_second;
            end
        end
    end

    // ------------------------------------------------------------
    // reads: live word and input image
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            word_rdata <= `ECC_ZERO16;
        end else if (word_rd && word_addr == `ECC_WORD_FIRST) begin
            word_rdata <= cnt_q[15:0];
        end else if (word_rd && word_addr == `ECC_WORD_SECOND) begin
            word_rdata <= cnt_q[31:16];
        end else if (word_rd) begin
            word_rdata <= `ECC_ZERO16;  // unmapped word
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            image_first  <= `ECC_ZERO16;
            image_second <= `ECC_ZERO16;
        end else if (image_update) begin
            image_first  <= cnt_q[15:0];
            image_second <= cnt_q[31:16];
        end
    end

    // ------------------------------------------------------------
    // event posting around the handler
    // ------------------------------------------------------------
    ecc_post_type post_q;   // handler running or not
    logic [1:0]   pend_q;   // events waiting for next entry
    logic [1:0]   flag_q;   // visible flag bits
    logic [1:0]   ev;       // events of this cycle

    always_comb begin
        ev = `ECC_ZERO2;
        ev[`ECC_FLAG_FIRST]  = match_first || match_casc;
        ev[`ECC_FLAG_SECOND] = match_second || match_casc;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            post_q <= ECC_IDLE;
        end else begin
            case (post_q)
                ECC_IDLE:    if (handler_enter) post_q <= ECC_HANDLER;
                ECC_HANDLER: if (handler_exit)  post_q <= ECC_IDLE;
                default:     post_q <= ECC_IDLE;
            endcase
        end
    end

    // flags post on handler entry; they persist until cleared
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_q <= `ECC_ZERO2;
            flag_q <= `ECC_ZERO2;
        end else if (post_q == ECC_IDLE && handler_enter) begin
            flag_q <= (flag_q & ~flag_clr) | pend_q | ev;
            pend_q <= `ECC_ZERO2;
        end else begin
            flag_q <= flag_q & ~flag_clr;
            pend_q <= pend_q | ev;
        end
    end

    assign counter_event_flag_byte = {`ECC_FLAG_PAD, flag_q};

    // request one cycle after the match
    always_ff @(posedge clock) begin
        if (rst) begin
            counter_irq <= 1'b0;
        end else begin
            counter_irq <= match_casc || match_first || match_second;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // first counter back at zero with the request raised
    sequence s_first_done;
        cnt_q[15:0] == `ECC_ZERO16 && counter_irq;
    endsequence
    // whole cascade back at zero with the request raised
    sequence s_casc_done;
        cnt_q == `ECC_ZERO32 && counter_irq;
    endsequence
    a_casc_clear: assert property (
        @(posedge clock) disable iff (rst)
        match_casc |=> s_casc_done)
        else $error("cascade match did not clear and request");
    a_first_clear: assert property (
        @(posedge clock) disable iff (rst)
        match_first |=> s_first_done)
        else $error("first match did not clear and request");
    a_wr_clears: assert property (
        @(posedge clock) disable iff (rst)
        (wr_first && !cascade_q && !start && !hit_first && !match_first)
        |=> cnt_q[15:0] == `ECC_ZERO16)
        else $error("write did not clear first count");
    // in cascade only a first-pin edge, a write or start may move it
    a_second_quiet: assert property (
        @(posedge clock) disable iff (rst)
        (cascade_q && !hit_first && !word_wr && !start)
        |=> cnt_q == $past(cnt_q))
        else $error("cascade count moved without a first edge");
    // no set flag may drop in a cycle with no reset write to any bit
    a_flags_hold: assert property (
        @(posedge clock) disable iff (rst)
        (flag_clr == `ECC_ZERO2)
        |=> (flag_q & $past(flag_q)) == $past(flag_q))
        else $error("flag cleared by itself");
    a_flags_post: assert property (
        @(posedge clock) disable iff (rst)
        (post_q == ECC_IDLE && handler_enter)
        |=> (flag_q & ($past(pend_q) | $past(ev)))
            == ($past(pend_q) | $past(ev)))
        else $error("held events not posted on handler entry");
    a_image_sample: assert property (
        @(posedge clock) disable iff (rst)
        image_update |=> {image_second, image_first} == $past(cnt_q))
        else $error("input image did not take the count");
endmodule

// ===== hdl/ecc_regs.svh
// constants of the edge counter block: word addresses, flag bits, fill values
`ifndef ECC_REGS_SVH
`define ECC_REGS_SVH
`define ECC_WORD_FIRST   8'h24
`define ECC_WORD_SECOND  8'h26
`define ECC_FLAG_FIRST   0
`define ECC_FLAG_SECOND  1
`define ECC_ZERO16       16'h0000
`define ECC_ZERO32       32'h00000000
`define ECC_ONE32        32'h00000001
`define ECC_ONE16        16'h0001
`define ECC_MODE_OFF     2'h0
`define ECC_ZERO2        2'h0
`define ECC_FLAG_PAD     6'h00
`endif

// ===== hdl/ecc_pkg.sv
// types shared by the edge counter block
package ecc_pkg;
    // edge selection of one counter input
    typedef enum logic [1:0] {
        ECC_OFF     = 2'h0,
        ECC_RISING  = 2'h1,
        ECC_FALLING = 2'h2
    } ecc_edge_type;
    // posting of flag events around the handler
    typedef enum logic [1:0] {
        ECC_IDLE    = 2'h1,
        ECC_HANDLER = 2'h2
    } ecc_post_type;
endpackage

// ===== hdl/ecc_edge_sync.sv
// pin synchroniser and edge qualifier for one counter input
`include "ecc_regs.svh"
module ecc_edge_sync
    import ecc_pkg::*;
(
    input  wire logic         clock,     // system clock
    input  wire logic         rst,       // synchronous reset
    input  wire logic         pin,       // raw counter pin
    input  wire ecc_edge_type edge_sel,  // edge to count
    output logic              edge_hit   // one-cycle qualified edge
);
    // ------------------------------------------------------------
    // three-stage synchroniser
    // ------------------------------------------------------------
    logic s1_q;  // metastable stage, read only by s2
    logic s2_q;  // second stage
    logic s3_q;  // third stage
    logic lvl_q; // accepted level
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // ------------------------------------------------------------
    // level accepted once stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            lvl_q <= s3_q;
        end
    end
    // edge against accepted level; one pulse per change in the selected direction
    always_comb begin
        edge_hit = 1'b0;
        case (edge_sel)
            ECC_RISING:  edge_hit = (s2_q == s3_q) && s3_q && !lvl_q;
            ECC_FALLING: edge_hit = (s2_q == s3_q) && !s3_q && lvl_q;
            default:     edge_hit = 1'b0;
        endcase
    end
endmodule

// ===== tb/ecc_pulse_gen.sv
// model of the external pulse source feeding the two counter pins
module ecc_pulse_gen (
    input  wire logic clock,       // system clock
    input  wire logic fire_first,  // request one pulse on first pin
    input  wire logic fire_second, // request one pulse on second pin
    output logic      pin_first,   // first counter pin
    output logic      pin_second   // second counter pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // pulse shaping
    // ----------------------------------------------------------------
    logic [3:0] left_a_q = 4'h0; // high cycles left, first pin
    logic [3:0] left_b_q = 4'h0; // high cycles left, second pin
    // six cycles high: long enough to clear the three-flop synchroniser,
    // and the source idles low so each pulse has one rise and one fall
    always_ff @(posedge clock) begin
        left_a_q <= fire_first ? 4'h6 : left_a_q - {3'h0, left_a_q != 4'h0};
        left_b_q <= fire_second ? 4'h6 : left_b_q - {3'h0, left_b_q != 4'h0};
    end
    assign pin_first  = (left_a_q != 4'h0);
    assign pin_second = (left_b_q != 4'h0);
endmodule

// ===== tb/test_edge_counter_compare_cascade.sv
// self-checking bench of the edge counter block
module test_edge_counter_compare_cascade;
    import ecc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic        sel;  // 0 pulse first pin, 1 second pin
        logic [7:0]  addr; // word read afterwards
        logic [15:0] exp;  // expected live count
    } ecc_row_type;
    logic         clock = 1'b0, rst = 1'b1, cfg_cascade = 1'b0;
    logic         start = 1'b0, word_rd = 1'b0, word_wr = 1'b0;
    logic         image_update = 1'b0, handler_enter = 1'b0;
    logic         handler_exit = 1'b0, fire_first = 1'b0;
    logic         fire_second = 1'b0, counter_irq, pin_first, pin_second;
    ecc_edge_type cfg_first_edge = ECC_RISING;
    ecc_edge_type cfg_second_edge = ECC_FALLING;
    logic [31:0]  cfg_compare = 32'h00020003; // second 2, first 3
    logic [7:0]   word_addr = 8'h00, counter_event_flag_byte;
    logic [15:0]  prim = 16'h0000, sec = 16'h0000, word_rdata, image_first;
    logic [15:0]  image_second;
    logic [1:0]   flag_clr = 2'h0;
    int           err_total = 0, num_checks = 0, irq_n = 0, cyc_n = 0;
    ecc_row_type  rows [5] = '{'{1'b0, 8'h24, 16'h0001},
                               '{1'b1, 8'h26, 16'h0001},
                               '{1'b0, 8'h24, 16'h0002},
                               '{1'b0, 8'h24, 16'h0000},
                               '{1'b1, 8'h26, 16'h0000}};
    // ----------------------------------------------------------------
    // clock, instances, request and timeout watch
    // ----------------------------------------------------------------
    initial begin
        forever #2.5 clock = ~clock;
    end
    ecc_pulse_gen gen (.clock(clock), .fire_first(fire_first),
        .fire_second(fire_second), .pin_first(pin_first),
        .pin_second(pin_second));
    ecc_counter dut (.clock(clock), .rst(rst), .pin_first(pin_first),
        .pin_second(pin_second), .cfg_first_edge(cfg_first_edge),
        .cfg_second_edge(cfg_second_edge), .cfg_cascade(cfg_cascade),
        .cfg_compare(cfg_compare), .start(start), .word_addr(word_addr),
        .word_rd(word_rd), .word_wr(word_wr), .primary_accumulator(prim),
        .secondary_accumulator(sec), .word_rdata(word_rdata),
        .image_update(image_update), .image_first(image_first),
        .image_second(image_second), .handler_enter(handler_enter),
        .handler_exit(handler_exit), .flag_clr(flag_clr),
        .counter_event_flag_byte(counter_event_flag_byte),
        .counter_irq(counter_irq));
    // the request is a one-cycle pulse, so it is counted at every edge
    always @(posedge clock) begin
        if (counter_irq === 1'b1) irq_n++;
        cyc_n++;
        if (cyc_n == 4000) begin
            err_total++;
            stop_test();
        end
    end
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    // one pulse from the source, then time for sync and counting
    task automatic pulse(input logic sel);
        fire_first = ~sel;
        fire_second = sel;
        tick(1);
        fire_first = 1'b0;
        fire_second = 1'b0;
        tick(20);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        word_addr = a;
        word_rd = 1'b1;
        tick(1);
        word_rd = 1'b0;
        tick(1);
        chk(word_rdata, exp, "word read");
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] hi, lo);
        word_addr = a;
        sec = hi;
        prim = lo;
        word_wr = 1'b1;
        tick(1);
        word_wr = 1'b0;
        tick(1);
    endtask
    // one bit-reset write of the flag byte
    task automatic clr(input logic [1:0] b);
        flag_clr = b;
        tick(1);
        flag_clr = 2'h0;
        tick(1);
    endtask
    task automatic strobe(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(2);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(8);
        rst = 1'b0;
        tick(1);
        chk({8'h00, counter_event_flag_byte}, 16'h0000, "flags at reset");
        pulse(1'b0);
        rd(8'h24, 16'h0000);
        strobe(start);
        foreach (rows[i]) begin
            pulse(rows[i].sel);
            rd(rows[i].addr, rows[i].exp);
        end
        chk(16'(irq_n), 16'h0002, "request count");
        chk({8'h00, counter_event_flag_byte}, 16'h0000, "flags early");
        strobe(handler_enter);
        chk({8'h00, counter_event_flag_byte}, 16'h0003, "flags");
        strobe(handler_exit);
        clr(2'h1);
        chk({8'h00, counter_event_flag_byte}, 16'h0002, "flag clr");
        clr(2'h2);
        chk({8'h00, counter_event_flag_byte}, 16'h0000, "flag clr b");
        pulse(1'b0);
        pulse(1'b1);
        strobe(image_update);
        pulse(1'b0);
        rd(8'h24, 16'h0002);
        rd(8'h26, 16'h0001);
        chk(image_first, 16'h0001, "image");
        chk(image_second, 16'h0001, "image b");
        wr(8'h24, 16'h0000, 16'h0002);
        rd(8'h24, 16'h0000);
        rd(8'h26, 16'h0001);
        pulse(1'b0);
        rd(8'h24, 16'h0001);
        pulse(1'b0);
        rd(8'h24, 16'h0000);
        chk(16'(irq_n), 16'h0003, "new compare");
        wr(8'h26, 16'h0000, 16'h0005);
        rd(8'h26, 16'h0000);
        cfg_cascade = 1'b1;
        cfg_first_edge = ECC_FALLING;
        strobe(start);
        wr(8'h24, 16'h0001, 16'h0003);
        pulse(1'b1);
        repeat (3) pulse(1'b0);
        rd(8'h24, 16'h0003);
        rd(8'h26, 16'h0000);
        chk(16'(irq_n), 16'h0003, "no early match");
        wr(8'h26, 16'h0000, 16'h0000);
        rd(8'h24, 16'h0000);
        wr(8'h24, 16'h0000, 16'h0003);
        pulse(1'b1);
        pulse(1'b0);
        pulse(1'b0);
        rd(8'h24, 16'h0002);
        rd(8'h26, 16'h0000);
        pulse(1'b0);
        rd(8'h24, 16'h0000);
        chk(16'(irq_n), 16'h0004, "cascade request");
        strobe(handler_enter);
        chk({8'h00, counter_event_flag_byte}, 16'h0003, "both");
        stop_test();
    end
endmodule
